// ==== rtl/cts_status.sv ====
`timescale 1ns/10ps
`default_nettype none
module cts_status
  import cts_pkg::*;
(
  input  wire logic          CLOCK,
  input  wire logic          RST,
  input  wire logic [7:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic [31:0]        RDATA,
  input  wire cts_pkg::cts_ev_t  EV,
  input  wire cts_pkg::cts_flt_t FLT,
  input  wire logic [3:0]    CH_LEVEL,
  input  wire logic [3:0]    CH_BUF_WRITE,
  input  wire logic [3:0]    CH_CAPTURE,
  input  wire logic [3:0]    CH_CC_READ,
  input  wire logic          PER_BUF_WRITE,
  input  wire logic          WAVE_BUF_WRITE,
  input  wire logic          PATT_BUF_WRITE,
  input  wire logic          DEBUG_MODE,
  input  wire logic [7:0]    NONREC_OUTPUT_ENABLE,
  input  wire logic [7:0]    NONREC_OUTPUT_VALUE,
  input  wire logic [7:0]    WAVE_IN,
  output logic [7:0]         WAVE_OUT,
  output logic               COUNTER_HALT,
  output logic               IRQ
);
  import cts_pkg::*;

  logic [2:0]  flag_r;
  logic [2:0]  inten_r;
  logic [4:0]  ctrl_r;
  logic [1:0]  nonrec_r;
  logic        fault_a_r;
  logic        fault_b_r;
  logic        dbg_fault_r;
  logic        stop_r;
  logic [3:0]  ccbv;
  logic        per_valid;
  logic        wave_valid;
  logic        patt_valid;
  logic [31:0] status;
  logic [31:0] rd_nxt;
  logic        wr_flag;
  logic        wr_stat;
  logic        lock_upd;
  logic [2:0]  ev_set;

  assign wr_flag  = WR && (ADDR == ADDR_INTFLAG);
  assign wr_stat  = WR && (ADDR == ADDR_STATUS);
  assign lock_upd = ctrl_r[CT_LOCK];
  assign ev_set  = {EV.counter_event, EV.retrigger, EV.overflow};

  // events are registered, so each flag shows one cycle after its event
  always_ff @(posedge CLOCK) begin
    if (RST)
      flag_r <= 3'h0;
    else
      flag_r <= ev_set | (flag_r & ~(wr_flag ? WDATA[2:0] : 3'h0));
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      inten_r <= 3'h0;
    else if (WR && ADDR == ADDR_INTENABLE)
      inten_r <= WDATA[2:0];
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      ctrl_r <= 5'h00;
    else if (WR && ADDR == ADDR_CTRL)
      ctrl_r <= WDATA[4:0];
  end

  assign IRQ = |(flag_r & inten_r);

  // nonrecoverable state holds while input active; clear ignored then
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_nr
      always_ff @(posedge CLOCK) begin
        if (RST)
          nonrec_r[g] <= 1'b0;
        else if (FLT.nonrec_in[g])
          nonrec_r[g] <= 1'b1;
        else if (wr_stat && WDATA[ST_NR+g])
          nonrec_r[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (RST)
      fault_a_r <= 1'b0;
    else if (FLT.rec_input_a)
      fault_a_r <= 1'b1;
    else if (FLT.resume_a || (wr_stat && WDATA[ST_FA]))
      fault_a_r <= 1'b0;
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      fault_b_r <= 1'b0;
    else if (FLT.rec_input_b)
      fault_b_r <= 1'b1;
    else if (FLT.resume_b || (wr_stat && WDATA[ST_FB]))
      fault_b_r <= 1'b0;
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      dbg_fault_r <= 1'b0;
    else if (DEBUG_MODE && ctrl_r[CT_DBGDET])
      dbg_fault_r <= 1'b1;
    else if (!DEBUG_MODE && wr_stat && WDATA[ST_DBGF])
      dbg_fault_r <= 1'b0;
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      stop_r <= STATUS_RESET[ST_STOP];
    else if (EV.stop_cmd || (EV.update && EV.single_shot))
      stop_r <= 1'b1;
    else if (EV.count_step)
      stop_r <= 1'b0;
  end

  // capture channels clear on read; compare channels on update or lock_update write
  generate
    for (g = 0; g < 4; g++) begin : g_cc
      cts_bvbit u_bv (
        .CLOCK (CLOCK),
        .RST   (RST),
        .set_i (ctrl_r[CT_CAPT] ? CH_CAPTURE[g] : CH_BUF_WRITE[g]),
        .clr_i (ctrl_r[CT_CAPT] ? CH_CC_READ[g]
                : (EV.update || (wr_stat && lock_upd && WDATA[ST_CCBV+g]))),
        .q_o   (ccbv[g])
      );
    end
  endgenerate

  cts_bvbit u_per (
    .CLOCK (CLOCK),
    .RST   (RST),
    .set_i (PER_BUF_WRITE),
    .clr_i ((EV.update && lock_upd) || (wr_stat && WDATA[ST_PER])),
    .q_o   (per_valid)
  );

  cts_bvbit u_wave (
    .CLOCK (CLOCK),
    .RST   (RST),
    .set_i (WAVE_BUF_WRITE),
    .clr_i ((EV.update && lock_upd) || (wr_stat && WDATA[ST_WAVE])),
    .q_o   (wave_valid)
  );

  cts_bvbit u_patt (
    .CLOCK (CLOCK),
    .RST   (RST),
    .set_i (PATT_BUF_WRITE),
    .clr_i ((EV.update && lock_upd) || (wr_stat && WDATA[ST_PATT])),
    .q_o   (patt_valid)
  );

  // counter resumes from its own count; restart is software's job before clear
  assign COUNTER_HALT = dbg_fault_r | (|nonrec_r)
                      | (fault_a_r & ctrl_r[CT_HALTA]) | (fault_b_r & ctrl_r[CT_HALTB]);

  generate
    for (g = 0; g < 8; g++) begin : g_wo
      always_ff @(posedge CLOCK) begin
        if (RST)
          WAVE_OUT[g] <= 1'b0;
        else if (dbg_fault_r && NONREC_OUTPUT_ENABLE[g])
          WAVE_OUT[g] <= NONREC_OUTPUT_VALUE[g];
        else
          WAVE_OUT[g] <= WAVE_IN[g];
      end
    end
  endgenerate

  always_comb begin
    status = 32'h0;
    status[ST_CMP+3:ST_CMP]   = CH_LEVEL;
    status[ST_CCBV+3:ST_CCBV] = ccbv;
    status[ST_NR+1:ST_NR]     = nonrec_r;
    status[ST_FB]             = fault_b_r;
    status[ST_FA]             = fault_a_r;
    status[ST_FIN+3:ST_FIN]   = {FLT.nonrec_in[1], FLT.nonrec_in[0],
                                 FLT.rec_input_b, FLT.rec_input_a};
    status[ST_PER]            = per_valid;
    status[ST_WAVE]           = wave_valid;
    status[ST_PATT]           = patt_valid;
    status[ST_DBGF]           = dbg_fault_r;
    status[ST_RAMP]           = (EV.ramp_mode != RAMP_SINGLE) && EV.ramp_cycle_b;
    status[ST_STOP]           = stop_r;
  end

  always_comb begin
    case (ADDR)
      ADDR_INTENABLE: rd_nxt = {29'h0, inten_r};
      ADDR_INTFLAG:   rd_nxt = {29'h0, flag_r};
      ADDR_STATUS:    rd_nxt = status;
      ADDR_CTRL:      rd_nxt = {27'h0, ctrl_r};
      default:        rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      RDATA <= 32'h0;
    else if (RD)
      RDATA <= rd_nxt;
    else
      RDATA <= 32'h0;
  end

  stop_reset_a: assert property (@(posedge CLOCK) $fell(RST) |-> status[ST_STOP])
    else $error("stopped not set after reset");
  overflow_flag_a: assert property (@(posedge CLOCK) disable iff (RST) EV.overflow |=> flag_r[FL_OVERFLOW])
    else $error("overflow flag missed");
  retrig_flag_a: assert property (@(posedge CLOCK) disable iff (RST) EV.retrigger |=> flag_r[FL_RETRIG])
    else $error("retrigger flag missed");
  event_flag_a: assert property (@(posedge CLOCK) disable iff (RST) EV.counter_event |=> flag_r[FL_COUNT])
    else $error("counter event flag missed");
  flag_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_flag && WDATA[FL_OVERFLOW] && !EV.overflow) |=> !flag_r[FL_OVERFLOW])
    else $error("overflow flag not cleared");
  irq_gate_a: assert property (@(posedge CLOCK) disable iff (RST) IRQ == |(flag_r & inten_r))
    else $error("interrupt mismatch");
  nr_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
    FLT.nonrec_in[0] |=> nonrec_r[0])
    else $error("nonrecoverable state not held");
  dbg_halt_a: assert property (@(posedge CLOCK) disable iff (RST) dbg_fault_r |-> COUNTER_HALT)
    else $error("counter not halted in debug fault");
  ramp_single_a: assert property (@(posedge CLOCK) disable iff (RST)
    (EV.ramp_mode == RAMP_SINGLE) |-> !status[ST_RAMP])
    else $error("ramp index set in single ramp");
  stop_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    (EV.count_step && !EV.stop_cmd && !EV.update) |=> !stop_r)
    else $error("stopped not cleared by count");
  dbg_keep_a: assert property (@(posedge CLOCK) disable iff (RST)
    (dbg_fault_r && DEBUG_MODE) |=> dbg_fault_r)
    else $error("debug fault cleared in debug mode");
endmodule // cts_status
`default_nettype wire

// ==== rtl/cts_pkg.sv ====
// Operation
// - counter event sets counter-event flag next cycle
// - retrigger sets retrigger flag next cycle
// - overflow sets overflow flag next cycle
// - write one clears flag, zero ignored
// - status at 0x30, resets to 0x1
// - bits 27:24 mirror channel output levels
// - compare buffer valid: set write, clear update
// - capture buffer valid: set capture, clear read
// - nonrecoverable fault state clears only input low
// - fault clear resumes from last count
// - fault b state set, hw/sw clear, releases
// - fault a state behaves like fault b
// - bits 11:8 show live fault inputs
// - period buffer valid set/clear rules
// - waveform buffer valid set/clear rules
// - pattern buffer valid set/clear rules
// - debug fault state set debug, clear outside
// - debug fault halts counter, forces outputs
// - ramp index shows cycle b in dual ramp
// - stopped sets on stop, clears on count
`default_nettype none
package cts_pkg;
  localparam logic [7:0] ADDR_INTENABLE = 8'h28;
  localparam logic [7:0] ADDR_INTFLAG   = 8'h2c;
  localparam logic [7:0] ADDR_STATUS    = 8'h30;
  localparam logic [7:0] ADDR_CTRL      = 8'h40;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0001;
  localparam int FL_OVERFLOW = 0;
  localparam int FL_RETRIG   = 1;
  localparam int FL_COUNT    = 2;
  localparam int ST_STOP = 0;
  localparam int ST_RAMP = 1;
  localparam int ST_DBGF = 3;
  localparam int ST_PATT = 5;
  localparam int ST_WAVE = 6;
  localparam int ST_PER  = 7;
  localparam int ST_FIN  = 8;
  localparam int ST_FA   = 12;
  localparam int ST_FB   = 13;
  localparam int ST_NR   = 14;
  localparam int ST_CCBV = 16;
  localparam int ST_CMP  = 24;
  localparam int CT_LOCK   = 0;
  localparam int CT_DBGDET = 1;
  localparam int CT_HALTA = 2;
  localparam int CT_HALTB = 3;
  localparam int CT_CAPT  = 4;
  localparam logic [1:0] RAMP_SINGLE  = 2'h0;
  localparam logic [1:0] RAMP_DUALALT = 2'h1;
  localparam logic [1:0] RAMP_DUAL    = 2'h2;
  typedef struct packed {
    logic       counter_event;
    logic       retrigger;
    logic       overflow;
    logic       update;
    logic       stop_cmd;
    logic       single_shot;
    logic       count_step;
    logic       ramp_cycle_b;
    logic [1:0] ramp_mode;
  } cts_ev_t;
  typedef struct packed {
    logic [1:0] nonrec_in;
    logic       rec_input_b;
    logic       rec_input_a;
    logic       resume_a;
    logic       resume_b;
  } cts_flt_t;
endpackage
`default_nettype wire

// ==== rtl/cts_bvbit.sv ====
`timescale 1ns/10ps
`default_nettype none
module cts_bvbit (
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);
  always_ff @(posedge CLOCK) begin
    if (RST)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end
endmodule // cts_bvbit
`default_nettype wire

// ==== verification/cts_status_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module cts_status_bench;
  import cts_pkg::*;
  logic        CLOCK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, rd_seen = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, r;
  cts_ev_t     EV = '0;
  cts_flt_t    FLT = '0;
  logic [3:0]  CH_LEVEL = 4'h0, CH_BUF_WRITE = 4'h0, CH_CAPTURE = 4'h0, CH_CC_READ = 4'h0;
  logic        PER_BUF_WRITE = 1'b0, WAVE_BUF_WRITE = 1'b0, PATT_BUF_WRITE = 1'b0, DEBUG_MODE = 1'b0;
  logic [7:0]  NONREC_OUTPUT_ENABLE = 8'h00, NONREC_OUTPUT_VALUE = 8'h00, WAVE_IN = 8'h00, WAVE_OUT;
  logic        COUNTER_HALT, IRQ;
  logic [31:0] exp_q[$];
  int          err_total = 0, total_checks = 0;

  always #20 CLOCK = ~CLOCK;

  cts_status cts_status_i (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EV(EV), .FLT(FLT), .CH_LEVEL(CH_LEVEL), .CH_BUF_WRITE(CH_BUF_WRITE),
    .CH_CAPTURE(CH_CAPTURE), .CH_CC_READ(CH_CC_READ), .PER_BUF_WRITE(PER_BUF_WRITE),
    .WAVE_BUF_WRITE(WAVE_BUF_WRITE), .PATT_BUF_WRITE(PATT_BUF_WRITE), .DEBUG_MODE(DEBUG_MODE),
    .NONREC_OUTPUT_ENABLE(NONREC_OUTPUT_ENABLE), .NONREC_OUTPUT_VALUE(NONREC_OUTPUT_VALUE),
    .WAVE_IN(WAVE_IN), .WAVE_OUT(WAVE_OUT), .COUNTER_HALT(COUNTER_HALT), .IRQ(IRQ));

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim();
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task step(input int n = 1);
    repeat (n) @(posedge CLOCK);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    step();
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    step();
    WR <= 1'b0;
  endtask

  // the expected word is queued with the request; the monitor pops it when the data stand
  task rd(input logic [7:0] a, input logic [31:0] e);
    step();
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    step();
    RD <= 1'b0;
  endtask

  task evp(input logic [9:0] p);
    step();
    EV <= cts_ev_t'(p);
    step();
    EV <= '0;
  endtask

  always @(posedge CLOCK) rd_seen <= RD;
  // sampled mid-cycle so the registered read data has settled
  always @(negedge CLOCK) if (rd_seen) check("rdata", RDATA, exp_q.pop_front());

  initial begin
    step(2000);
    err_total++;
    end_sim();
  end

  initial begin
    void'($urandom(52812));
    step(6);
    RST <= 1'b0;
    rd(ADDR_STATUS, STATUS_RESET);
    rd(ADDR_INTFLAG, 32'h0);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    rd(ADDR_STATUS, STATUS_RESET);
    for (int i = 0; i < 3; i++) begin
      evp(10'h080 << i);
      rd(ADDR_INTFLAG, (32'h2 << i) - 32'h1);
    end
    wr(ADDR_INTFLAG, 32'h2);
    rd(ADDR_INTFLAG, 32'h5);
    wr(ADDR_INTFLAG, 32'h0);
    rd(ADDR_INTFLAG, 32'h5);
    #1 check("irq", 32'(IRQ), 32'h0);
    wr(ADDR_INTENABLE, 32'h4);
    #1 check("irq", 32'(IRQ), 32'h1);
    wr(ADDR_INTFLAG, 32'h4);
    #1 check("irq", 32'(IRQ), 32'h0);
    step();
    EV <= cts_ev_t'(10'h080);
    ADDR <= ADDR_INTFLAG;
    WDATA <= 32'h1;
    WR <= 1'b1;
    step();
    EV <= '0;
    WR <= 1'b0;
    rd(ADDR_INTFLAG, 32'h1);
    wr(ADDR_INTFLAG, 32'h1);
    rd(ADDR_INTFLAG, 32'h0);
    evp(10'h008);
    rd(ADDR_STATUS, 32'h0);
    evp(10'h020);
    rd(ADDR_STATUS, 32'h1);
    evp(10'h008);
    evp(10'h050);
    rd(ADDR_STATUS, 32'h1);
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 2; c++) begin
        step();
        EV <= cts_ev_t'({7'h0, c[0], m[1:0]});
        rd(ADDR_STATUS, (m != 0 && c == 1) ? 32'h3 : 32'h1);
      end
    step();
    EV <= '0;
    repeat (4) begin
      r = $urandom;
      step();
      CH_LEVEL <= r[3:0];
      rd(ADDR_STATUS, {4'h0, r[3:0], 24'h1});
    end
    step();
    CH_LEVEL <= 4'h0;
    {CH_BUF_WRITE, PER_BUF_WRITE, WAVE_BUF_WRITE, PATT_BUF_WRITE} <= 7'h7f;
    step();
    {CH_BUF_WRITE, PER_BUF_WRITE, WAVE_BUF_WRITE, PATT_BUF_WRITE} <= 7'h00;
    rd(ADDR_STATUS, 32'h000f_00e1);
    evp(10'h040);
    rd(ADDR_STATUS, 32'h0000_00e1);
    wr(ADDR_STATUS, 32'h80);
    rd(ADDR_STATUS, 32'h0000_0061);
    wr(ADDR_CTRL, 32'h1);
    evp(10'h040);
    rd(ADDR_STATUS, 32'h1);
    step();
    CH_BUF_WRITE <= 4'hf;
    step();
    CH_BUF_WRITE <= 4'h0;
    wr(ADDR_STATUS, 32'h1_0000);
    rd(ADDR_STATUS, 32'h000e_0001);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STATUS, 32'h2_0000);
    rd(ADDR_STATUS, 32'h000e_0001);
    evp(10'h040);
    wr(ADDR_CTRL, 32'h10);
    step();
    CH_CAPTURE <= 4'h6;
    step();
    CH_CAPTURE <= 4'h0;
    rd(ADDR_STATUS, 32'h0006_0001);
    step();
    CH_CC_READ <= 4'h2;
    step();
    CH_CC_READ <= 4'h0;
    rd(ADDR_STATUS, 32'h0004_0001);
    step();
    CH_CC_READ <= 4'h4;
    step();
    CH_CC_READ <= 4'h0;
    rd(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h8);
    for (int i = 0; i < 4; i++) begin
      step();
      FLT <= cts_flt_t'(6'h4 << i);
      wr(ADDR_STATUS, 32'h1000 << i);
      rd(ADDR_STATUS, 32'h1 | (32'h1100 << i));
      if (i == 1) check("halt", 32'(COUNTER_HALT), 32'h1);
      step();
      FLT <= (i == 0) ? cts_flt_t'(6'h02) : cts_flt_t'(6'h00);
      step();
      FLT <= '0;
      if (i != 0) wr(ADDR_STATUS, 32'h1000 << i);
      rd(ADDR_STATUS, 32'h1);
      if (i == 1) check("halt", 32'(COUNTER_HALT), 32'h0);
    end
    r = $urandom;
    step();
    {NONREC_OUTPUT_ENABLE, NONREC_OUTPUT_VALUE, WAVE_IN} <= r[23:0];
    wr(ADDR_CTRL, 32'h2);
    DEBUG_MODE <= 1'b1;
    rd(ADDR_STATUS, 32'h9);
    #1 check("halt", 32'(COUNTER_HALT), 32'h1);
    check("wave", 32'(WAVE_OUT), 32'((r[23:16] & r[15:8]) | (~r[23:16] & r[7:0])));
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS, 32'h9);
    step();
    DEBUG_MODE <= 1'b0;
    rd(ADDR_STATUS, 32'h9);
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS, 32'h1);
    #1 check("halt", 32'(COUNTER_HALT), 32'h0);
    check("wave", 32'(WAVE_OUT), 32'(r[7:0]));
    step();
    end_sim();
  end
endmodule // cts_status_bench
`default_nettype wire
